// ==== inc/ext_exec_pkg.sv ====
`default_nettype none
package ext_exec_pkg;
    localparam logic [7:0] ESCAPE_CODE     = 8'hA5;
    localparam logic [7:0] OP_ALT_INC      = 8'hA3;
    localparam logic [7:0] OP_PC_JUMP      = 8'h73;
    localparam logic [7:0] OP_LEFT_SHIFT   = 8'h23;
    localparam logic [7:0] OP_CODE_READ    = 8'h93;
    localparam logic [7:0] OP_MAC          = 8'hA4;
    localparam logic [7:0] OP_IMM_LOAD     = 8'h90;
    localparam logic [7:0] OP_EXT_READ     = 8'hE0;
    localparam logic [7:0] OP_EXT_WRITE    = 8'hF0;
    localparam logic [15:0] PC_JUMP_STEP   = 16'h0002;
    localparam logic [15:0] PTR_RESET      = 16'h0000;
    localparam logic [39:0] ACCUM_RESET    = 40'h00_0000_0000;
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic [2:0] CYC_ALT_INC     = 3'd3;
    localparam logic [2:0] CYC_PC_JUMP     = 3'd3;
    localparam logic [2:0] CYC_LEFT_SHIFT  = 3'd2;
    localparam logic [2:0] CYC_CODE_READ   = 3'd3;
    localparam logic [2:0] CYC_IMM_LOAD    = 3'd4;
    localparam logic [3:0] CYC_MAC         = 4'd9;
    localparam logic [2:0] CYC_EXT_FAST    = 3'd3;
    localparam logic [2:0] CYC_EXT_SLOW    = 3'd5;

    typedef enum logic [1:0] {
        SPACE_EXTRA_RAM,
        SPACE_FLASH_DATA,
        SPACE_EXTERNAL_DATA
    } data_space_e;

    typedef struct packed {
        logic        req;
        logic        write;
        data_space_e space;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_s;

    typedef struct packed {
        logic overflow;
        logic carry;
    } flag_pair_s;
endpackage : ext_exec_pkg
`default_nettype wire

// ==== core/mac_unit.sv ====
`default_nettype none
module mac_unit
    import ext_exec_pkg::*;
(
    input  wire logic [39:0] m_i,
    input  wire logic [15:0] a_op_i,
    input  wire logic [15:0] b_op_i,
    output logic      [39:0] sum_o,
    output logic             overflow_o,
    output logic             negative_o
);
    logic signed [31:0] product;
    logic signed [39:0] prod_ext;

    always_comb begin
        product    = $signed(a_op_i) * $signed(b_op_i); // see (RL7)
        prod_ext   = 40'(product);
        sum_o      = m_i + prod_ext;
        // Overflow when both addends share a sign that the sum lacks
        overflow_o = (m_i[39] == prod_ext[39]) && (sum_o[39] != m_i[39]); // see (RL8)
        negative_o = sum_o[39];
    end
endmodule : mac_unit
`default_nettype wire

// ==== core/extended_instruction_exec.sv ====
`default_nettype none
// Notes on behaviour
// (RL1) Byte A5 opens every extended instruction; the next byte selects the operation.
// (RL2) Alternate increment adds one modulo 65536 to the unselected pointer, flags untouched.
// (RL3) Alternate increment is two bytes, A5 A3, and takes three cycles.
// (RL4) PC-relative jump targets PC+2 plus the unsigned accumulator, modulo 65536, flags kept.
// (RL5) Left shift moves the 40-bit accumulation register up one, bit 0 zero, flags kept.
// (RL6) Alternate code read loads A from program memory at A plus unselected pointer.
// (RL7) Multiply-accumulate adds the signed 16x16 product into the 40-bit register.
// (RL8) Multiply-accumulate sets overflow on signed overflow, else keeps it; carry is the sign.
// (RL9) Immediate load writes byte three high and byte four low into the unselected pointer.
// (RL10) Alternate external read loads A from the space addressed by the unselected pointer.
// (RL11) Alternate external read, A5 E0, takes three cycles in extra RAM, five elsewhere.
// (RL12) Alternate external write stores A at the unselected pointer's address.
// (RL13) Select bit zero makes the second pointer alternate, one makes the first alternate.
// (RL14) Alternate external write, A5 F0, takes three cycles in extra RAM, five elsewhere.
module extended_instruction_exec
    import ext_exec_pkg::*;
(
    input  wire logic                      CLK_I,
    input  wire logic                      RST_I,
    input  wire logic                      BYTE_VALID_I,
    input  wire logic [7:0]                BYTE_I,
    output logic                           BYTE_READY_O,
    input  wire logic [15:0]               PC_I,
    input  wire logic [7:0]                ACC_I,
    input  wire logic [7:0]                B_I,
    input  wire logic                      POINTER_SELECT_BIT_I,
    input  wire ext_exec_pkg::flag_pair_s  FLAGS_I,
    input  wire logic [7:0]                MEM_RDATA_I,
    input  wire ext_exec_pkg::data_space_e SPACE_I,
    output ext_exec_pkg::mem_req_s         MEM_REQ_O,
    output logic                           CODE_REQ_O,
    output logic [15:0]                    CODE_ADDR_O,
    output logic                           ACC_WE_O,
    output logic [7:0]                     ACC_O,
    output logic                           FLAGS_WE_O,
    output ext_exec_pkg::flag_pair_s       FLAGS_O,
    output logic                           PC_WE_O,
    output logic [15:0]                    PC_O,
    output logic                           DONE_O,
    output logic [15:0]                    FIRST_DATA_POINTER_O,
    output logic [15:0]                    SECOND_DATA_POINTER_O,
    output logic [39:0]                    ACCUM_O,
    output logic [7:0]                     A_EXTENSION_BYTE_O,
    output logic [7:0]                     B_EXTENSION_BYTE_O
);
    import ext_exec_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_OPCODE, S_IMM_HI, S_IMM_LO, S_EXEC
    } state_e;

    state_e      state_r;
    logic [7:0]  op_r;
    logic [7:0]  imm_hi_r;
    logic [3:0]  cnt_r;
    logic [3:0]  cnt_goal;
    logic [15:0] first_ptr_r;
    logic [15:0] second_ptr_r;
    logic [39:0] accum_r;
    logic [7:0]  ax_r;
    logic [7:0]  bx_r;
    logic [15:0] alt_ptr;
    logic [39:0] mac_sum;
    logic        mac_ovf;
    logic        mac_neg;
    logic        last_cycle;
    logic        shift_now;
    logic        imm_done;
    logic        finish;

    function automatic logic is_ext_mem(input logic [7:0] op);
        is_ext_mem = (op == OP_EXT_READ) || (op == OP_EXT_WRITE);
    endfunction : is_ext_mem

    assign alt_ptr = POINTER_SELECT_BIT_I ? first_ptr_r : second_ptr_r; // see (RL13)

    // Total cycles counted from the escape byte
    always_comb begin
        case (op_r)
            OP_ALT_INC:    cnt_goal = {1'b0, CYC_ALT_INC}; // see (RL3)
            OP_PC_JUMP:    cnt_goal = {1'b0, CYC_PC_JUMP};
            OP_LEFT_SHIFT: cnt_goal = {1'b0, CYC_LEFT_SHIFT};
            OP_CODE_READ:  cnt_goal = {1'b0, CYC_CODE_READ};
            OP_IMM_LOAD:   cnt_goal = {1'b0, CYC_IMM_LOAD};
            OP_MAC:        cnt_goal = CYC_MAC;
            OP_EXT_READ, OP_EXT_WRITE: begin
                // Slow spaces cost two extra cycles; see (RL11) see (RL14)
                cnt_goal = (SPACE_I == SPACE_EXTRA_RAM) ? {1'b0, CYC_EXT_FAST}
                                                        : {1'b0, CYC_EXT_SLOW};
            end
            default:       cnt_goal = 4'd2;
        endcase
    end

    assign last_cycle   = (state_r == S_EXEC) && (cnt_r >= cnt_goal - 4'd1);
    // Two-cycle shift completes on its opcode byte, the load on its last byte
    assign shift_now    = (state_r == S_OPCODE) && BYTE_VALID_I && (BYTE_I == OP_LEFT_SHIFT);
    assign imm_done     = (state_r == S_IMM_LO) && BYTE_VALID_I;
    assign finish       = last_cycle || shift_now || imm_done;
    assign BYTE_READY_O = (state_r == S_IDLE) || (state_r == S_OPCODE) ||
                          (state_r == S_IMM_HI) || (state_r == S_IMM_LO);

    mac_unit u_mac (
        .m_i        (accum_r),
        .a_op_i     ({ax_r, ACC_I}),
        .b_op_i     ({bx_r, B_I}),
        .sum_o      (mac_sum),
        .overflow_o (mac_ovf),
        .negative_o (mac_neg)
    );

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_r  <= S_IDLE;
            op_r     <= BYTE_RESET;
            imm_hi_r <= BYTE_RESET;
            cnt_r    <= 4'd0;
        end else begin
            case (state_r)
                S_IDLE: if (BYTE_VALID_I && BYTE_I == ESCAPE_CODE) begin
                    state_r <= S_OPCODE; // see (RL1)
                    cnt_r   <= 4'd1;
                end
                S_OPCODE: if (BYTE_VALID_I) begin
                    op_r    <= BYTE_I; // see (RL1)
                    state_r <= (BYTE_I == OP_IMM_LOAD)   ? S_IMM_HI :
                               (BYTE_I == OP_LEFT_SHIFT) ? S_IDLE   : S_EXEC;
                    cnt_r   <= 4'd2;
                end
                S_IMM_HI: if (BYTE_VALID_I) begin
                    imm_hi_r <= BYTE_I;
                    state_r  <= S_IMM_LO;
                end
                S_IMM_LO: if (BYTE_VALID_I) begin
                    state_r <= S_IDLE; // see (RL9)
                end
                S_EXEC: begin
                    cnt_r <= cnt_r + 4'd1;
                    if (last_cycle) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Data pointers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            first_ptr_r  <= PTR_RESET;
            second_ptr_r <= PTR_RESET;
        end else if (state_r == S_IMM_LO && BYTE_VALID_I) begin
            if (POINTER_SELECT_BIT_I) first_ptr_r <= {imm_hi_r, BYTE_I}; // see (RL9)
            else second_ptr_r <= {imm_hi_r, BYTE_I}; // see (RL9)
        end else if (last_cycle && op_r == OP_ALT_INC) begin
            // 16-bit add carries low byte into high byte; see (RL2)
            if (POINTER_SELECT_BIT_I) first_ptr_r <= first_ptr_r + 16'd1;
            else second_ptr_r <= second_ptr_r + 16'd1;
        end
    end

    // Accumulation register; extension bytes are held as operands
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            accum_r <= ACCUM_RESET;
            ax_r    <= BYTE_RESET;
            bx_r    <= BYTE_RESET;
        end else if (shift_now) begin
            accum_r <= {accum_r[38:0], 1'b0}; // see (RL5)
        end else if (last_cycle && op_r == OP_MAC) begin
            accum_r <= mac_sum; // see (RL7)
        end
    end

    // Outputs to core, registered
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            MEM_REQ_O   <= '0;
            CODE_REQ_O  <= 1'b0;
            CODE_ADDR_O <= PTR_RESET;
            ACC_WE_O    <= 1'b0;
            ACC_O       <= BYTE_RESET;
            FLAGS_WE_O  <= 1'b0;
            FLAGS_O     <= '0;
            PC_WE_O     <= 1'b0;
            PC_O        <= PTR_RESET;
            DONE_O      <= 1'b0;
        end else begin
            MEM_REQ_O.req <= 1'b0;
            CODE_REQ_O    <= 1'b0;
            ACC_WE_O      <= 1'b0;
            FLAGS_WE_O    <= 1'b0;
            PC_WE_O       <= 1'b0;
            DONE_O        <= finish;
            if (state_r == S_EXEC && cnt_r == 4'd2) begin
                if (is_ext_mem(op_r)) begin
                    MEM_REQ_O.req   <= 1'b1; // see (RL10) see (RL12)
                    MEM_REQ_O.write <= (op_r == OP_EXT_WRITE);
                    MEM_REQ_O.space <= SPACE_I;
                    MEM_REQ_O.addr  <= alt_ptr;
                    MEM_REQ_O.wdata <= ACC_I;
                end
                if (op_r == OP_CODE_READ) begin
                    CODE_REQ_O  <= 1'b1;
                    CODE_ADDR_O <= alt_ptr + {8'h00, ACC_I}; // see (RL6)
                end
            end
            if (last_cycle) begin
                case (op_r)
                    OP_PC_JUMP: begin
                        PC_WE_O <= 1'b1;
                        PC_O    <= PC_I + PC_JUMP_STEP + {8'h00, ACC_I}; // see (RL4)
                    end
                    OP_CODE_READ, OP_EXT_READ: begin
                        ACC_WE_O <= 1'b1; // see (RL6) see (RL10)
                        ACC_O    <= MEM_RDATA_I;
                    end
                    OP_MAC: begin
                        FLAGS_WE_O       <= 1'b1;
                        FLAGS_O.overflow <= FLAGS_I.overflow | mac_ovf; // see (RL8)
                        FLAGS_O.carry    <= mac_neg; // see (RL8)
                    end
                    default: ;
                endcase
            end
        end
    end

    assign FIRST_DATA_POINTER_O  = first_ptr_r;
    assign SECOND_DATA_POINTER_O = second_ptr_r;
    assign ACCUM_O               = accum_r;
    assign A_EXTENSION_BYTE_O    = ax_r;
    assign B_EXTENSION_BYTE_O    = bx_r;

    a_shift_zero: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL5)
        shift_now |=> accum_r == {$past(accum_r[38:0]), 1'b0})
        else $error("left shift result wrong");
    a_inc_wraps: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL2)
        (last_cycle && op_r == OP_ALT_INC && !POINTER_SELECT_BIT_I)
            |=> second_ptr_r == $past(second_ptr_r) + 16'd1)
        else $error("alternate increment wrong");
    a_inc_three: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL3)
        (state_r == S_OPCODE && BYTE_VALID_I && BYTE_I == OP_ALT_INC)
            |=> last_cycle)
        else $error("increment cycle count wrong");
    a_jump_target: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL4)
        (last_cycle && op_r == OP_PC_JUMP)
            |=> PC_WE_O && PC_O == $past(PC_I) + 16'd2 + {8'h00, $past(ACC_I)})
        else $error("jump target wrong");
    a_ext_slow: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL11)
        (state_r == S_EXEC && cnt_r == 4'd2 && op_r == OP_EXT_READ
            && SPACE_I != SPACE_EXTRA_RAM) |-> !last_cycle ##1 !last_cycle ##1 last_cycle)
        else $error("slow read length wrong");
    a_mem_alt_ptr: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL13)
        (state_r == S_EXEC && cnt_r == 4'd2 && is_ext_mem(op_r))
            |=> MEM_REQ_O.req && MEM_REQ_O.addr ==
                ($past(POINTER_SELECT_BIT_I) ? $past(first_ptr_r) : $past(second_ptr_r)))
        else $error("external access uses wrong pointer");
    a_mac_carry: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL8)
        (last_cycle && op_r == OP_MAC) |=> FLAGS_WE_O && FLAGS_O.carry == accum_r[39])
        else $error("carry does not follow sign");
    a_imm_load: assert property (@(posedge CLK_I) disable iff (RST_I) // see (RL9)
        (state_r == S_IMM_LO && BYTE_VALID_I && POINTER_SELECT_BIT_I)
            |=> first_ptr_r == {$past(imm_hi_r), $past(BYTE_I)})
        else $error("immediate load wrong");
endmodule : extended_instruction_exec
`default_nettype wire

// ==== testbench/ext_mem_model.sv ====
`default_nettype none
module ext_mem_model
    import ext_exec_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire ext_exec_pkg::mem_req_s mem_req_i,
    input  wire logic                   busy_i,
    input  wire logic                   code_sel_i,
    input  wire logic [17:0]            look_key_i,
    output logic [7:0]                  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] store [logic [17:0]];
    logic [7:0] noise_r = 8'h3C;

    function automatic logic [7:0] fill(input logic [17:0] k);
        return k[7:0] ^ k[15:8] ^ {6'h00, k[17:16]} ^ 8'h96;
    endfunction : fill

    // Data spaces keep what was written; unwritten cells read a fixed fill
    always @(posedge clk_i) begin
        noise_r <= noise_r + 8'h4B;
        if (mem_req_i.req === 1'b1 && mem_req_i.write === 1'b1) begin
            store[{mem_req_i.space, mem_req_i.addr}] = mem_req_i.wdata;
        end
    end

    // Outside an access the bus carries a changing pattern, never stale data
    always @(negedge clk_i or busy_i or look_key_i or code_sel_i) begin
        if (!busy_i) begin
            rdata_o = noise_r;
        end else if (!code_sel_i && store.exists(look_key_i)) begin
            rdata_o = store[look_key_i];
        end else begin
            rdata_o = fill(look_key_i);
        end
    end
endmodule : ext_mem_model
`default_nettype wire

// ==== testbench/extended_instruction_exec_tb_top.sv ====
`default_nettype none
module extended_instruction_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_exec_pkg::*;
    logic clk, rst, bval, psel, rdy, cq, awe, fwe, pwe, done, csel, busy, alt;
    logic [7:0] bb, acc, breg, rdata, acco, axo, bxo, wacc;
    logic [15:0] pc, ca, pco, p0, p1, ex;
    logic [15:0] dp [2];
    logic [39:0] acm, m_exp, sum;
    logic [31:0] prod, r;
    logic [17:0] key;
    flag_pair_s flags, flo;
    data_space_e space;
    mem_req_s mq, cap;
    logic s_pc, s_acc, s_flg;
    int fails, num_checks, cyc, seed, i, j;

    extended_instruction_exec DUT (.CLK_I(clk), .RST_I(rst), .BYTE_VALID_I(bval), .BYTE_I(bb),
        .BYTE_READY_O(rdy), .PC_I(pc), .ACC_I(acc), .B_I(breg), .POINTER_SELECT_BIT_I(psel),
        .FLAGS_I(flags), .MEM_RDATA_I(rdata), .SPACE_I(space), .MEM_REQ_O(mq), .CODE_REQ_O(cq),
        .CODE_ADDR_O(ca), .ACC_WE_O(awe), .ACC_O(acco), .FLAGS_WE_O(fwe), .FLAGS_O(flo),
        .PC_WE_O(pwe), .PC_O(pco), .DONE_O(done), .FIRST_DATA_POINTER_O(p0),
        .SECOND_DATA_POINTER_O(p1), .ACCUM_O(acm), .A_EXTENSION_BYTE_O(axo),
        .B_EXTENSION_BYTE_O(bxo));
    ext_mem_model MEM (.clk_i(clk), .mem_req_i(mq), .busy_i(busy), .code_sel_i(csel),
        .look_key_i(key), .rdata_o(rdata));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic send(input logic [7:0] b);
        logic ok;
        int k;
        bval = 1'b1;
        bb = b;
        for (k = 0; k < 20; k++) begin
            ok = rdy;
            @(posedge clk);
            if (ok === 1'b1) break;
        end
        if (k == 20) begin
            fails++;
            report_and_stop();
        end
        #1;
    endtask : send

    task automatic exec(input logic [7:0] op, input logic [15:0] imm, input int n);
        int t0;
        int k;
        {s_pc, s_acc, s_flg} = 3'b000;
        cap = '0;
        send(ESCAPE_CODE);
        t0 = cyc;
        send(op);
        if (op == OP_IMM_LOAD) begin
            send(imm[15:8]);
            send(imm[7:0]);
        end
        bval = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            if (mq.req === 1'b1) cap = mq;
            s_pc |= (pwe === 1'b1);
            s_acc |= (awe === 1'b1);
            s_flg |= (fwe === 1'b1);
        end
        check(48'(cyc - t0 + 1), 48'(n));
    endtask : exec

    initial begin
        {clk, bval, bb, psel, acc, breg, pc, flags, csel, busy, key, cyc} = '0;
        space = SPACE_EXTRA_RAM;
        fails = 0;
        num_checks = 0;
        seed = 32'h8dd7;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        check({p0, p1, 8'h00}, 40'h0);
        check(acm, ACCUM_RESET);
        m_exp = ACCUM_RESET;
        dp[0] = PTR_RESET;
        dp[1] = PTR_RESET;
        for (i = 0; i < 14; i++) begin
            r = $random(seed);
            {psel, acc, breg, flags} = r[18:0];
            pc = (i == 0) ? 16'hFFFF : r[31:16];
            space = data_space_e'(r[20:19] == 2'd3 ? 2'd0 : r[20:19]);
            alt = ~psel;
            send({1'b0, r[6:0]});
            ex = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h00FF : 16'($random(seed));
            exec(OP_IMM_LOAD, ex, CYC_IMM_LOAD);
            dp[alt] = ex;
            check({p0, p1}, {dp[0], dp[1]});
            exec(OP_ALT_INC, 16'h0, CYC_ALT_INC);
            dp[alt] = dp[alt] + 16'h0001;
            check({s_flg, p0, p1}, {1'b0, dp[0], dp[1]});
            exec(OP_PC_JUMP, 16'h0, CYC_PC_JUMP);
            check({s_pc, s_acc, s_flg, pco}, {3'b100, pc + PC_JUMP_STEP + {8'h00, acc}});
            csel = 1'b1;
            busy = 1'b1;
            key = {2'b00, dp[alt] + {8'h00, acc}};
            exec(OP_CODE_READ, 16'h0, CYC_CODE_READ);
            check({s_acc, s_flg, ca, acco}, {2'b10, key[15:0], MEM.fill(key)});
            check({p0, p1}, {dp[0], dp[1]});
            csel = 1'b0;
            key = {space, dp[alt]};
            wacc = acc;
            exec(OP_EXT_WRITE, 16'h0, space == SPACE_EXTRA_RAM ? 3 : 5);
            check(cap, {2'b11, space, dp[alt], wacc});
            acc = ~acc;
            exec(OP_EXT_READ, 16'h0, space == SPACE_EXTRA_RAM ? 3 : 5);
            check({s_acc, cap.req, cap.write, cap.addr, acco}, {3'b110, dp[alt], wacc});
            busy = 1'b0;
            prod = $signed({BYTE_RESET, acc}) * $signed({BYTE_RESET, breg});
            sum = m_exp + {{8{prod[31]}}, prod};
            exec(OP_MAC, 16'h0, CYC_MAC);
            check(acm, sum);
            check({axo, bxo}, {BYTE_RESET, BYTE_RESET});
            check({s_flg, flo}, {1'b1, flags.overflow |
                ((m_exp[39] == prod[31]) && (sum[39] != m_exp[39])), sum[39]});
            m_exp = sum;
            for (j = 0; j < 3; j++) begin
                exec(OP_LEFT_SHIFT, 16'h0, CYC_LEFT_SHIFT);
                m_exp = {m_exp[38:0], 1'b0};
                check({s_flg, acm}, {1'b0, m_exp});
            end
        end
        report_and_stop();
    end
endmodule : extended_instruction_exec_tb_top
`default_nettype wire
